// [rtl/csie_clock_select_irq.sv]
// Clock source select and interrupt enable registers with APB access
//
// Summary of operation
// - Tick request raised only while tick enable bit 7 is set and flag set.
// - Lock-change request raised only while enable bit 4 and flag set.
// - Oscillator request raised only while enable bit 1 and flag set.
// - Interrupt enable register is always readable and writable.
// - Clock select writes are ignored while the write guard is set.
// - Special mode: clock select bits 7, 6 and 3 to 0 writable when unguarded.
// - Normal mode: source, pseudo stop, run bits, tick select writable.
// - Watchdog select locks after watchdog control write; one retry after loss.
// - Source bit 7 picks loop clock when set, crystal when clear.
// - Source bit clears only when qualified; set by loss or full stop.
// - Pseudo stop bit 6 keeps oscillator running in stop.
// - Tick runs in pseudo stop only with bit 3 and tick select set.
// - Otherwise the tick counter freezes in stop, keeping its count.
// - Watchdog runs in pseudo stop only with bit 2 and its select set.
// - Otherwise the watchdog counter freezes in stop, keeping its count.
// - Tick select bit 1 picks crystal; any change restarts the tick period.
// - Tick select set only when qualified; cleared on qualification loss.
// - Watchdog select bit 0 picks crystal; change restarts its period.
// - Watchdog select set only when qualified; cleared on loss.
// - Qualified status is read-only and cleared on entering full stop.
// - Lock-change flag set on lock change, cleared by writing one.
// - Oscillator-change flag set on status change, cleared by writing one.
// - Tick flag set at end of each period, cleared by writing one.
`timescale 1ns/1ps
module csie_clock_select_irq
	import csie_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins from the oscillator, loop and mode straps
	input wire logic osc_qualified_pin,
	input wire logic loop_lock_pin,
	input wire logic special_mode_pin,
	// Core events on this clock
	input wire logic stop_active,
	input wire logic tick_timeout,
	// Clock selection outputs
	output logic sysclk_from_loop,
	output logic pseudo_stop_select,
	output logic tick_clock_select,
	output logic watchdog_clock_select,
	// Counter control outputs
	output logic tick_count_enable,
	output logic watchdog_count_enable,
	output logic tick_restart,
	output logic watchdog_restart,
	// Interrupt requests
	output logic tick_irq,
	output logic loop_settle_irq,
	output logic osc_fault_irq
);
	// ****************************************
	// State
	// ****************************************
	typedef struct packed {
		logic [7:0] int_en;
		logic [7:0] clks;
		logic write_guard;
		logic [7:0] wdog_ctl;
		logic wd_locked;
		logic wd_once;
		logic osc_qualified;
		logic lock_q;
		logic stop_q;
		logic tick_restart;
		logic wdog_restart;
		logic tick_cnt_en;
		logic wdog_cnt_en;
		logic [31:0] rdata;
	} csie_state_s;

	localparam csie_state_s RESET_STATE = '{
		int_en: INT_RESET,
		clks: CLKS_RESET,
		write_guard: WRITE_GUARD_RESET,
		wdog_ctl: WDOG_RESET,
		wd_locked: 1'b0,
		wd_once: 1'b0,
		osc_qualified: 1'b0,
		lock_q: 1'b0,
		stop_q: 1'b0,
		tick_restart: 1'b0,
		wdog_restart: 1'b0,
		tick_cnt_en: 1'b1,
		wdog_cnt_en: 1'b1,
		rdata: 32'h0000_0000
	};

	csie_state_s r_reg;
	csie_state_s r_next;

	logic [SYNC_W-1:0] sync_q;
	logic special, osc_now, lock_now, setup, wr, mapped, wd_ok;
	logic wr_flags, wr_int, wr_clks, wr_wdog, wr_write_guard;
	logic [7:0] clks_mask, clks_val, flags_rd;
	logic tick_flag, loop_settle_change_flag, osc_change_flag;

	// ****************************************
	// Pin synchronisers
	// ****************************************
	csie_sync2 #(.WIDTH(SYNC_W)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.async_in({special_mode_pin, loop_lock_pin, osc_qualified_pin}),
		.sync_out(sync_q)
	);

	// Synchronised levels
	assign special = sync_q[SYNC_SPECIAL];
	assign lock_now = sync_q[SYNC_LOCK];
	// Entering full stop drops qualification
	assign osc_now = sync_q[SYNC_OSC]
		&& !(stop_active && !r_reg.clks[CLK_PSEUDO_STOP_SELECT]);

	// ****************************************
	// APB decode
	// ****************************************
	assign setup = psel && !penable;
	assign wr = psel && penable && pwrite;
	assign wr_flags = wr && (paddr == ADDR_FLAGS);
	assign wr_int = wr && (paddr == ADDR_INT);
	assign wr_clks = wr && (paddr == ADDR_CLKS) && !r_reg.write_guard;
	assign wr_wdog = wr && (paddr == ADDR_WDOG);
	assign wr_write_guard = wr && (paddr == ADDR_WRITE_GUARD);

	// Address map check
	always_comb
	begin
		if (paddr == ADDR_FLAGS)
			mapped = 1'b1;
		else if (paddr == ADDR_INT)
			mapped = 1'b1;
		else if (paddr == ADDR_CLKS)
			mapped = 1'b1;
		else if (paddr == ADDR_WDOG)
			mapped = 1'b1;
		else if (paddr == ADDR_WRITE_GUARD)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end

	// Zero wait states, error on unmapped address
	assign pready = penable;
	assign pslverr = psel && penable && !mapped;

	// ****************************************
	// Event flags
	// ****************************************
	csie_event_flag u_tick_flag (
		.pclk(pclk),
		.presetn(presetn),
		.set_pulse(tick_timeout),
		.clear_pulse(wr_flags && pwdata[BIT_TICK]),
		.enable(r_reg.int_en[BIT_TICK]),
		.flag(tick_flag),
		.irq(tick_irq)
	);

	csie_event_flag u_lock_flag (
		.pclk(pclk),
		.presetn(presetn),
		.set_pulse(lock_now != r_reg.lock_q),
		.clear_pulse(wr_flags && pwdata[BIT_LOCK]),
		.enable(r_reg.int_en[BIT_LOCK]),
		.flag(loop_settle_change_flag),
		.irq(loop_settle_irq)
	);

	csie_event_flag u_osc_flag (
		.pclk(pclk),
		.presetn(presetn),
		.set_pulse(osc_now != r_reg.osc_qualified),
		.clear_pulse(wr_flags && pwdata[BIT_OSC]),
		.enable(r_reg.int_en[BIT_OSC]),
		.flag(osc_change_flag),
		.irq(osc_fault_irq)
	);

	// Flag register read image
	always_comb
	begin
		flags_rd = 8'h00;
		flags_rd[BIT_TICK] = tick_flag;
		flags_rd[BIT_LOCK] = loop_settle_change_flag;
		flags_rd[BIT_LOCK_STAT] = r_reg.lock_q;
		flags_rd[BIT_OSC] = osc_change_flag;
		flags_rd[BIT_OSCQ] = r_reg.osc_qualified;
	end

	// ****************************************
	// Clock select write filter
	// ****************************************
	// Watchdog select open until locked, or once after a loss
	assign wd_ok = !r_reg.wd_locked || r_reg.wd_once;

	// Writable bits by mode
	always_comb
	begin
		if (special)
			clks_mask = CLKS_SPECIAL_MASK;
		else if (wd_ok)
			clks_mask = CLKS_NORMAL_MASK | CLKS_WDOG_MASK;
		else
			clks_mask = CLKS_NORMAL_MASK;
	end

	// New clock select value after software and hardware
	always_comb
	begin
		clks_val = r_reg.clks;
		if (wr_clks)
		begin
			clks_val = (r_reg.clks & ~clks_mask) | (pwdata[7:0] & clks_mask);
			if (!r_reg.osc_qualified)
			begin
				clks_val[CLK_LOOP] = 1'b1;
				clks_val[CLK_TICK_SEL] = 1'b0;
				clks_val[CLK_WDOG_SEL] = 1'b0;
			end
		end
		if (!osc_now)
		begin
			clks_val[CLK_LOOP] = 1'b1;
			clks_val[CLK_TICK_SEL] = 1'b0;
			clks_val[CLK_WDOG_SEL] = 1'b0;
		end
		if (stop_active && !r_reg.stop_q && !r_reg.clks[CLK_PSEUDO_STOP_SELECT])
			clks_val[CLK_LOOP] = 1'b1;
	end

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		r_next = r_reg;
		r_next.clks = clks_val;
		r_next.osc_qualified = osc_now;
		r_next.lock_q = lock_now;
		r_next.stop_q = stop_active;
		// Interrupt enables accept any write
		if (wr_int)
			r_next.int_en = pwdata[7:0] & INT_MASK;
		if (wr_write_guard)
			r_next.write_guard = pwdata[BIT_GUARD];
		if (wr_wdog)
		begin
			r_next.wdog_ctl = pwdata[7:0];
			r_next.wd_locked = 1'b1;
		end
		// Second chance after hardware cleared the watchdog select
		if (!osc_now && r_reg.clks[CLK_WDOG_SEL])
			r_next.wd_once = 1'b1;
		else if (r_reg.wd_locked && !special && clks_val[CLK_WDOG_SEL]
			&& !r_reg.clks[CLK_WDOG_SEL])
			r_next.wd_once = 1'b0;
		// Restart on any change of a counter clock select
		r_next.tick_restart = clks_val[CLK_TICK_SEL]
			!= r_reg.clks[CLK_TICK_SEL];
		r_next.wdog_restart = clks_val[CLK_WDOG_SEL]
			!= r_reg.clks[CLK_WDOG_SEL];
		// Counters run outside stop, or in pseudo stop when allowed
		r_next.tick_cnt_en = !stop_active || (clks_val[CLK_PSEUDO_STOP_SELECT]
			&& clks_val[CLK_TICK_RUN]
			&& clks_val[CLK_TICK_SEL]);
		r_next.wdog_cnt_en = !stop_active || (clks_val[CLK_PSEUDO_STOP_SELECT]
			&& clks_val[CLK_WDOG_RUN]
			&& clks_val[CLK_WDOG_SEL]);
		// Read data captured in the setup cycle
		if (setup && !pwrite)
		begin
			r_next.rdata = 32'h0000_0000;
			if (paddr == ADDR_FLAGS)
				r_next.rdata[7:0] = flags_rd;
			else if (paddr == ADDR_INT)
				r_next.rdata[7:0] = r_reg.int_en;
			else if (paddr == ADDR_CLKS)
				r_next.rdata[7:0] = r_reg.clks;
			else if (paddr == ADDR_WDOG)
				r_next.rdata[7:0] = r_reg.wdog_ctl;
			else if (paddr == ADDR_WRITE_GUARD)
				r_next.rdata[BIT_GUARD] = r_reg.write_guard;
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_reg <= RESET_STATE;
		else
			r_reg <= r_next;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign prdata = r_reg.rdata;
	assign sysclk_from_loop = r_reg.clks[CLK_LOOP];
	assign pseudo_stop_select = r_reg.clks[CLK_PSEUDO_STOP_SELECT];
	assign tick_clock_select = r_reg.clks[CLK_TICK_SEL];
	assign watchdog_clock_select = r_reg.clks[CLK_WDOG_SEL];
	assign tick_count_enable = r_reg.tick_cnt_en;
	assign watchdog_count_enable = r_reg.wdog_cnt_en;
	assign tick_restart = r_reg.tick_restart;
	assign watchdog_restart = r_reg.wdog_restart;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	chk_tick_irq_raise: assert property (
		(tick_timeout && r_reg.int_en[BIT_TICK] && !wr_int) |=> tick_irq)
		else $error("tick request missing after timeout");
	chk_lock_irq_gate: assert property (
		!r_reg.int_en[BIT_LOCK] |-> !loop_settle_irq)
		else $error("lock request while disabled");
	chk_osc_irq_hold: assert property (
		(osc_fault_irq && !wr_flags && !wr_int) |=> osc_fault_irq)
		else $error("oscillator request dropped early");
	chk_int_write: assert property (
		wr_int |=> r_reg.int_en == ($past(pwdata[7:0]) & INT_MASK))
		else $error("interrupt enable write lost");
	chk_guard_block: assert property (
		(wr && paddr == ADDR_CLKS && r_reg.write_guard && osc_now
		&& !stop_active) |=> $stable(r_reg.clks))
		else $error("guarded clock select write took effect");
	chk_osc_loss_sel: assert property (
		!r_reg.osc_qualified |-> r_reg.clks[CLK_LOOP]
		&& !r_reg.clks[CLK_TICK_SEL] && !r_reg.clks[CLK_WDOG_SEL])
		else $error("selects not forced on lost qualification");
	chk_tick_freeze: assert property (
		(stop_active && !r_next.clks[CLK_TICK_RUN]) |=> !tick_count_enable)
		else $error("tick runs in stop without run bit");
	chk_tick_restart: assert property (
		tick_restart == $changed(r_reg.clks[CLK_TICK_SEL]))
		else $error("tick restart not one pulse per select change");
	chk_wd_lock: assert property (
		(r_reg.wd_locked && !r_reg.wd_once && !special)
		|=> !$rose(r_reg.clks[CLK_WDOG_SEL]))
		else $error("locked watchdog select was set");
	chk_lock_flag_set: assert property (
		(lock_now != r_reg.lock_q) |=> loop_settle_change_flag)
		else $error("lock change not flagged");
endmodule // csie_clock_select_irq

// [rtl/csie_pkg.sv]
// Constants shared by the clock select and interrupt enable block
package csie_pkg;
	// ****************************************
	// Register map
	// ****************************************
	// Register indexes, byte address is four times the index
	localparam logic [9:0] IDX_FLAGS = 10'h037;
	localparam logic [9:0] IDX_INT = 10'h038;
	localparam logic [9:0] IDX_CLKS = 10'h039;
	localparam logic [9:0] IDX_WDOG = 10'h03c;
	localparam logic [9:0] IDX_WRITE_GUARD = 10'h03f;
	localparam logic [11:0] ADDR_FLAGS = {IDX_FLAGS, 2'b00};
	localparam logic [11:0] ADDR_INT = {IDX_INT, 2'b00};
	localparam logic [11:0] ADDR_CLKS = {IDX_CLKS, 2'b00};
	localparam logic [11:0] ADDR_WDOG = {IDX_WDOG, 2'b00};
	localparam logic [11:0] ADDR_WRITE_GUARD = {IDX_WRITE_GUARD, 2'b00};

	// ****************************************
	// Field positions
	// ****************************************
	// Interrupt enable and flag register bits
	localparam int BIT_TICK = 7;
	localparam int BIT_LOCK = 4;
	localparam int BIT_LOCK_STAT = 3;
	localparam int BIT_OSC = 1;
	localparam int BIT_OSCQ = 0;
	// Clock select register bits
	localparam int CLK_LOOP = 7;
	localparam int CLK_PSEUDO_STOP_SELECT = 6;
	localparam int CLK_TICK_RUN = 3;
	localparam int CLK_WDOG_RUN = 2;
	localparam int CLK_TICK_SEL = 1;
	localparam int CLK_WDOG_SEL = 0;
	// Protection register guard bit
	localparam int BIT_GUARD = 0;

	// ****************************************
	// Masks and reset values
	// ****************************************
	localparam logic [7:0] INT_MASK = 8'h92;
	localparam logic [7:0] CLKS_SPECIAL_MASK = 8'hcf;
	localparam logic [7:0] CLKS_NORMAL_MASK = 8'hce;
	localparam logic [7:0] CLKS_WDOG_MASK = 8'h01;
	localparam logic [7:0] INT_RESET = 8'h00;
	localparam logic [7:0] CLKS_RESET = 8'h80;
	localparam logic [7:0] WDOG_RESET = 8'h00;
	localparam logic WRITE_GUARD_RESET = 1'b0;

	// Synchroniser lanes for pin inputs
	localparam int SYNC_W = 3;
	localparam int SYNC_OSC = 0;
	localparam int SYNC_LOCK = 1;
	localparam int SYNC_SPECIAL = 2;
endpackage

// [rtl/csie_sync2.sv]
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module csie_sync2
#(
	parameter int WIDTH = 1
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Asynchronous in, synchronised out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} csie_sync_s;

	csie_sync_s r_reg;
	csie_sync_s r_next;

	// First stage feeds only the second stage
	always_comb
	begin
		r_next.meta = async_in;
		r_next.stable = r_reg.meta;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign sync_out = r_reg.stable;
endmodule // csie_sync2

// [rtl/csie_event_flag.sv]
// Sticky event flag with write-one clear and gated request
`timescale 1ns/1ps
module csie_event_flag
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Event, software clear and enable
	input wire logic set_pulse,
	input wire logic clear_pulse,
	input wire logic enable,
	// Flag and request
	output logic flag,
	output logic irq
);
	typedef struct packed {
		logic flag;
	} csie_flag_s;

	csie_flag_s r_reg;
	csie_flag_s r_next;

	// Set wins over a clear in the same cycle
	always_comb
	begin
		r_next = r_reg;
		if (set_pulse)
			r_next.flag = 1'b1;
		else if (clear_pulse)
			r_next.flag = 1'b0;
	end

	// State register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign flag = r_reg.flag;
	assign irq = r_reg.flag && enable;
endmodule // csie_event_flag

// [verification/csie_testbench.sv]
// Self-checking testbench for the clock select and interrupt enable block
`timescale 1ns/1ps
module testbench
	import csie_pkg::*;
;
	// ****************************************
	// Signals
	// ****************************************
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r;
	logic osc_qualified_pin, loop_lock_pin, special_mode_pin;
	logic stop_active, tick_timeout;
	logic sysclk_from_loop, pseudo_stop_select;
	logic tick_clock_select, watchdog_clock_select;
	logic tick_count_enable, watchdog_count_enable;
	logic tick_restart, watchdog_restart;
	logic tick_irq, loop_settle_irq, osc_fault_irq;
	logic [7:0] stop_tab [4] = '{8'h4f, 8'h47, 8'h4b, 8'h4c};
	logic [7:0] irq_bit [3] = '{8'h80, 8'h10, 8'h02};
	int mismatches = 0;
	int n_compared = 0;
	int n_trst = 0;
	int n_wrst = 0;
	integer seed = 32'hd9e7b0d5;

	// Device under test
	csie_clock_select_irq u_csie_clock_select_irq (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .osc_qualified_pin(osc_qualified_pin),
		.loop_lock_pin(loop_lock_pin), .special_mode_pin(special_mode_pin),
		.stop_active(stop_active), .tick_timeout(tick_timeout),
		.sysclk_from_loop(sysclk_from_loop),
		.pseudo_stop_select(pseudo_stop_select),
		.tick_clock_select(tick_clock_select),
		.watchdog_clock_select(watchdog_clock_select),
		.tick_count_enable(tick_count_enable),
		.watchdog_count_enable(watchdog_count_enable),
		.tick_restart(tick_restart), .watchdog_restart(watchdog_restart),
		.tick_irq(tick_irq), .loop_settle_irq(loop_settle_irq),
		.osc_fault_irq(osc_fault_irq));

	// ****************************************
	// Clock, restart pulse counters, watchdog
	// ****************************************
	initial
	begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// Count cycles in which each restart pulse is high
	always @(posedge pclk)
	begin
		if (tick_restart === 1'b1) n_trst++;
		if (watchdog_restart === 1'b1) n_wrst++;
	end

	// Cut a hang short
	initial
	begin
		repeat (5000) @(posedge pclk);
		$display("[ERR] watchdog expected finish seen timeout");
		mismatches++;
		close_out();
	end

	// ****************************************
	// Tasks and functions
	// ****************************************
	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e)
		begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			mismatches++;
		end
	endtask

	// One APB transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the answer; only the bench watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h00_0000, d});
	endtask

	task automatic rdchk(input string nm, input logic [11:0] a,
		input logic [7:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, {24'h00_0000, e}, rd);
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask

	// Raise one event source: tick, lock change, oscillator change
	task automatic fire(input int i);
		@(posedge pclk);
		case (i)
			0: tick_timeout <= 1'b1;
			1: loop_lock_pin <= ~loop_lock_pin;
			default: osc_qualified_pin <= ~osc_qualified_pin;
		endcase
		@(posedge pclk);
		tick_timeout <= 1'b0;
		wait_cyc(5);
	endtask

	// Counter may run in stop only in pseudo stop with run and select set
	function automatic logic cnt_exp(input logic [7:0] c, input int run,
		input int sel);
		return c[6] & c[run] & c[sel];
	endfunction

	// ****************************************
	// Main sequence
	// ****************************************
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		presetn = 1'b0;
		osc_qualified_pin = 1'b1;
		loop_lock_pin = 1'b0;
		special_mode_pin = 1'b0;
		stop_active = 1'b0;
		tick_timeout = 1'b0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and unmapped access
		rdchk("int_reset", ADDR_INT, 8'h00);
		rdchk("clks_reset", ADDR_CLKS, 8'h80);
		rdchk("unmapped", 12'h100, 8'h00);
		chk("unmapped_err", 1'b1, er);
		wait_cyc(4);
		wr(ADDR_FLAGS, 8'hff);
		rdchk("flags_idle", ADDR_FLAGS, 8'h01);
		chk("count_en_run", 2'b11, {tick_count_enable, watchdog_count_enable});
		// Interrupt enables stay writable with the guard set
		wr(ADDR_WRITE_GUARD, 8'h01);
		repeat (8)
		begin
			r = $random(seed);
			wr(ADDR_INT, r[7:0]);
			rdchk("int_rw", ADDR_INT, r[7:0] & 8'h92);
		end
		wr(ADDR_CLKS, 8'h4e);
		rdchk("clks_guarded", ADDR_CLKS, 8'h80);
		wr(ADDR_WRITE_GUARD, 8'h00);
		// Normal mode, watchdog select lock and one retry
		wr(ADDR_CLKS, 8'h4f);
		rdchk("clks_normal", ADDR_CLKS, 8'h4f);
		chk("sysclk_osc", 1'b0, sysclk_from_loop);
		chk("sel_outputs", 4'b0111, {sysclk_from_loop, pseudo_stop_select,
			tick_clock_select, watchdog_clock_select});
		wr(ADDR_WDOG, 8'h00);
		wr(ADDR_CLKS, 8'h4e);
		rdchk("wdog_locked", ADDR_CLKS, 8'h4f);
		@(posedge pclk);
		osc_qualified_pin <= 1'b0;
		wait_cyc(6);
		rdchk("clks_osc_loss", ADDR_CLKS, 8'hcc);
		wr(ADDR_CLKS, 8'h0e);
		rdchk("clks_unqual", ADDR_CLKS, 8'h8c);
		@(posedge pclk);
		osc_qualified_pin <= 1'b1;
		// Oscillator startup time before any pseudo stop entry
		wait_cyc(6);
		wr(ADDR_CLKS, 8'h4f);
		rdchk("wdog_retry", ADDR_CLKS, 8'h4f);
		wr(ADDR_CLKS, 8'h4e);
		rdchk("retry_used", ADDR_CLKS, 8'h4f);
		chk("tick_restarts", 32'h0000_0003, n_trst);
		chk("wdog_restarts", 32'h0000_0003, n_wrst);
		// Special mode, counters in pseudo stop
		@(posedge pclk);
		special_mode_pin <= 1'b1;
		stop_active <= 1'b1;
		wait_cyc(4);
		for (int i = 0; i < 4; i++)
		begin
			wr(ADDR_CLKS, stop_tab[i]);
			rdchk("clks_special", ADDR_CLKS, stop_tab[i]);
			wait_cyc(2);
			chk("count_en_stop", {cnt_exp(stop_tab[i], 3, 1),
				cnt_exp(stop_tab[i], 2, 0)},
				{tick_count_enable, watchdog_count_enable});
		end
		// Full stop drops qualification and forces the selects
		wr(ADDR_FLAGS, 8'hff);
		wr(ADDR_CLKS, 8'h0f);
		wait_cyc(3);
		rdchk("clks_full_stop", ADDR_CLKS, 8'h8c);
		rdchk("flags_full_stop", ADDR_FLAGS, 8'h02);
		chk("count_en_freeze", 2'b00,
			{tick_count_enable, watchdog_count_enable});
		@(posedge pclk);
		stop_active <= 1'b0;
		special_mode_pin <= 1'b0;
		wait_cyc(6);
		chk("count_en_resume", 2'b11,
			{tick_count_enable, watchdog_count_enable});
		// Interrupt requests: masked, raised, held, cleared
		wr(ADDR_FLAGS, 8'hff);
		for (int i = 0; i < 3; i++)
		begin
			wr(ADDR_INT, ~irq_bit[i] & 8'h92);
			fire(i);
			chk("irq_masked", 3'b000,
				{tick_irq, loop_settle_irq, osc_fault_irq});
			wr(ADDR_INT, irq_bit[i]);
			wait_cyc(1);
			chk("irq_raised", 3'b100 >> i,
				{tick_irq, loop_settle_irq, osc_fault_irq});
			wr(ADDR_FLAGS, 8'h00);
			wait_cyc(1);
			chk("irq_held", 3'b100 >> i,
				{tick_irq, loop_settle_irq, osc_fault_irq});
			wr(ADDR_FLAGS, irq_bit[i]);
			wait_cyc(1);
			chk("irq_cleared", 3'b000,
				{tick_irq, loop_settle_irq, osc_fault_irq});
		end
		// Reset in mid-run restores selects, count enables, requests and the clock select and enable registers
		@(posedge pclk);
		presetn <= 1'b0;
		wait_cyc(2);
		chk("rst_outputs", 9'h118, {sysclk_from_loop, pseudo_stop_select,
			tick_clock_select, watchdog_clock_select, tick_count_enable,
			watchdog_count_enable, tick_irq, loop_settle_irq,
			osc_fault_irq});
		@(posedge pclk);
		presetn <= 1'b1;
		rdchk("clks_rst", ADDR_CLKS, 8'h80);
		rdchk("int_rst", ADDR_INT, 8'h00);
		// Lock pin high after reset shows as a lock change
		wait_cyc(4);
		rdchk("flags_rst", ADDR_FLAGS, 8'h18);
		close_out();
	end
endmodule // testbench
